// >>> verilog/amc_pkg.sv
// Package: map, reset values, fields and types of the motion register bank
package amc_pkg;
  localparam logic [6:0] SLAVE_ADDR = 7'h0f;
  localparam logic [7:0] A_CT = 8'h0c;
  localparam logic [7:0] A_SUP = 8'h0f;
  localparam logic [7:0] A_OCUR = 8'h10;
  localparam logic [7:0] A_OPRE = 8'h11;
  localparam logic [7:0] A_AX = 8'h12;
  localparam logic [7:0] A_AY = 8'h13;
  localparam logic [7:0] A_AZ = 8'h14;
  localparam logic [7:0] A_EVT = 8'h16;
  localparam logic [7:0] A_WAX = 8'h17;
  localparam logic [7:0] A_STAT = 8'h18;
  localparam logic [7:0] A_REL = 8'h1a;
  localparam logic [7:0] A_MAIN = 8'h1b;
  localparam logic [7:0] A_OMSK = 8'h1c;
  localparam logic [7:0] A_FEAT = 8'h1d;
  localparam logic [7:0] A_IPIN = 8'h1e;
  localparam logic [7:0] A_AMSK = 8'h1f;
  localparam logic [7:0] A_TTIM = 8'h28;
  localparam logic [7:0] A_WTIM = 8'h29;
  localparam logic [7:0] A_BTIM = 8'h2a;
  localparam logic [7:0] A_WTHR = 8'h5a;
  localparam logic [7:0] A_BTHR = 8'h5b;
  localparam logic [7:0] A_TANG = 8'h5c;
  localparam logic [7:0] A_HYST = 8'h5f;
  localparam logic [7:0] CT_IDLE = 8'h55;
  localparam logic [7:0] CT_ALT = 8'haa;
  localparam logic [5:0] ORIENT_RST = 6'h20;
  localparam logic [7:0] MAIN_RST = 8'h00;
  localparam logic [7:0] OMSK_RST = 8'h3f;
  localparam logic [7:0] FEAT_RST = 8'h06;
  localparam logic [7:0] IPIN_RST = 8'h08;
  localparam logic [7:0] AMSK_RST = 8'he0;
  localparam logic [7:0] TIM_RST = 8'h00;
  localparam logic [7:0] THR_RST = 8'h00;
  localparam logic [7:0] TANG_RST = 8'h00;
  localparam logic [7:0] HYST_RST = 8'h00;
  localparam int MAIN_TPE = 0;
  localparam int MAIN_WUFE = 1;
  localparam int MAIN_B2SE = 2;
  localparam int MAIN_ODR = 3;
  localparam int FEAT_OWUF = 0;
  localparam int FEAT_OB2S = 2;
  localparam int FEAT_CTC = 4;
  localparam int IPIN_IEA = 3;
  localparam int IPIN_IEN = 4;
  localparam int EVT_ORIENT = 0;
  localparam int EVT_WAKE = 1;
  localparam int EVT_SLEEP = 2;
  // Rate codes: 1, 3, 10 and 40 Hz
  localparam logic [1:0] ODR_1HZ = 2'h0;
  localparam logic [1:0] ODR_3HZ = 2'h1;
  localparam logic [1:0] ODR_10HZ = 2'h2;
  localparam logic [1:0] ODR_40HZ = 2'h3;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ADDR = 3'h1,
    ST_ACKA = 3'h3,
    ST_WR = 3'h2,
    ST_ACKW = 3'h6,
    ST_RD = 3'h7,
    ST_RACK = 3'h5
  } amc_state_t;

  typedef struct packed {
    logic [7:0] main;
    logic [7:0] omsk;
    logic [7:0] feat;
    logic [7:0] ipin;
    logic [7:0] amsk;
    logic [7:0] ttim;
    logic [7:0] wtim;
    logic [7:0] btim;
    logic [7:0] wthr;
    logic [7:0] bthr;
    logic [7:0] tang;
    logic [7:0] hyst;
  } amc_cfg_t;

  typedef struct packed {
    logic tick;
    logic [5:0] orient;
    logic [5:0] ax;
    logic [5:0] ay;
    logic [5:0] az;
    logic wake;
    logic sleep;
    logic [5:0] wake_axis;
    logic active;
  } amc_core_t;

  typedef struct packed {
    logic scl_m;
    logic scl_s;
    logic scl_p;
    logic sda_m;
    logic sda_s;
    logic sda_p;
    amc_state_t fsm;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [7:0] ptr;
    logic rw;
    logic first;
    logic more;
    logic sda_oe;
    amc_cfg_t cfg;
    logic [5:0] ocur;
    logic [5:0] opre;
    logic [5:0] ax;
    logic [5:0] ay;
    logic [5:0] az;
    logic [2:0] evt;
    logic [5:0] wax;
    logic unread;
    logic ovr;
    logic pend;
  } amc_st_t;
endpackage

// >>> verilog/amc_regs.sv
// Motion sensor register bank behind a serial two-wire slave port
// Behaviour
// - 23 byte registers at mapped serial addresses
// - Test response reads 55, aa while requested
// - Each test response read restores 55
// - Read-only supplier code at 0x0f
// - Orientation updates per rate tick, held during read
// - Orientation one-hot bits 5..0, top bits zero
// - Current orientation resets to left (0x20)
// - Previous orientation keeps state before last change
// - Samples sit in bits 7..2
// - X, Y, Z samples at 0x12..0x14
// - Event bits: sleep 2, wake 1, orientation 0
// - Sleep flag set on move to inactive
// - Wake flag set on move to active
// - Orientation flag set on orientation change
// - Event registers may refresh each rate tick
// - Wake axis register flags causing direction
// - Overrun bit 5, cleared by sample read
// - Status bit 4 ORs events, release clears
// - Status bits 3..2 show rate in use
// - Release read clears events and idles pin
// - Test request forces aa, read clears it
// - Rate codes 1, 3, 10, 40 Hz
// - Address auto-increments across multi-byte transfers
`timescale 1ns/100ps
module amc_regs #(
  // Arbitrary neutral value
  parameter logic [7:0] SUPPLIER_CODE = 8'h5a
) (
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  input wire amc_pkg::amc_core_t core_in,
  output amc_pkg::amc_cfg_t cfg_out,
  output logic [1:0] rate_used_out,
  output logic irq_pin_out
);
  import amc_pkg::*;

  amc_st_t q, d;
  logic rise, fall, start, stop, hold, go, ld, wr, int_act;
  logic [1:0] rate;
  logic [7:0] rbyte;

  assign rise = q.scl_s & ~q.scl_p;
  assign fall = ~q.scl_s & q.scl_p;
  assign start = q.scl_s & q.scl_p & q.sda_p & ~q.sda_s;
  assign stop = q.scl_s & q.scl_p & ~q.sda_p & q.sda_s;
  // Sampling stalls while a byte is being shifted out
  assign hold = (q.fsm == ST_RD) || (q.fsm == ST_RACK);
  assign go = (core_in.tick | q.pend) & ~hold;
  assign int_act = |q.evt;

  // Sleep/wake rates only apply once either detector is enabled
  always_comb begin
    if (q.cfg.main[MAIN_B2SE] | q.cfg.main[MAIN_WUFE]) begin
      rate = core_in.active ? q.cfg.feat[FEAT_OWUF +: 2]
                            : q.cfg.feat[FEAT_OB2S +: 2];
    end else begin
      rate = q.cfg.main[MAIN_ODR +: 2];
    end
  end

  always_comb begin
    case (q.ptr)
      A_CT: rbyte = q.cfg.feat[FEAT_CTC] ? CT_ALT : CT_IDLE;
      A_SUP: rbyte = SUPPLIER_CODE;
      A_OCUR: rbyte = {2'h0, q.ocur};
      A_OPRE: rbyte = {2'h0, q.opre};
      A_AX: rbyte = {q.ax, 2'h0};
      A_AY: rbyte = {q.ay, 2'h0};
      A_AZ: rbyte = {q.az, 2'h0};
      A_EVT: rbyte = {5'h0, q.evt};
      A_WAX: rbyte = {2'h0, q.wax};
      A_STAT: rbyte = {2'h0, q.ovr, int_act, rate, 2'h0};
      A_MAIN: rbyte = q.cfg.main;
      A_OMSK: rbyte = q.cfg.omsk;
      A_FEAT: rbyte = q.cfg.feat;
      A_IPIN: rbyte = q.cfg.ipin;
      A_AMSK: rbyte = q.cfg.amsk;
      A_TTIM: rbyte = q.cfg.ttim;
      A_WTIM: rbyte = q.cfg.wtim;
      A_BTIM: rbyte = q.cfg.btim;
      A_WTHR: rbyte = q.cfg.wthr;
      A_BTHR: rbyte = q.cfg.bthr;
      A_TANG: rbyte = q.cfg.tang;
      A_HYST: rbyte = q.cfg.hyst;
      default: rbyte = 8'h00;
    endcase
  end

  always_comb begin
    d = q;
    ld = 1'b0;
    wr = 1'b0;
    d.scl_m = scl_in;
    d.scl_s = q.scl_m;
    d.scl_p = q.scl_s;
    d.sda_m = sda_in;
    d.sda_s = q.sda_m;
    d.sda_p = q.sda_s;
    case (q.fsm)
      ST_ADDR: begin
        if (rise) begin
          d.sh = {q.sh[6:0], q.sda_s};
          d.cnt = q.cnt + 4'h1;
        end else if (fall && q.cnt == 4'h8) begin
          if (q.sh[7:1] == SLAVE_ADDR) begin
            d.fsm = ST_ACKA;
            d.rw = q.sh[0];
            d.sda_oe = 1'b1;
          end else begin
            d.fsm = ST_IDLE;
          end
        end
      end
      ST_ACKA: begin
        if (fall) begin
          d.cnt = 4'h0;
          d.first = 1'b1;
          if (q.rw) begin
            ld = 1'b1;
            d.fsm = ST_RD;
          end else begin
            d.sda_oe = 1'b0;
            d.fsm = ST_WR;
          end
        end
      end
      ST_WR: begin
        if (rise) begin
          d.sh = {q.sh[6:0], q.sda_s};
          d.cnt = q.cnt + 4'h1;
        end else if (fall && q.cnt == 4'h8) begin
          d.fsm = ST_ACKW;
          d.sda_oe = 1'b1;
          d.first = 1'b0;
          if (q.first) begin
            d.ptr = q.sh;
          end else begin
            wr = 1'b1;
            d.ptr = q.ptr + 8'h1;
          end
        end
      end
      ST_ACKW: begin
        if (fall) begin
          d.sda_oe = 1'b0;
          d.cnt = 4'h0;
          d.fsm = ST_WR;
        end
      end
      ST_RD: begin
        if (rise) begin
          d.cnt = q.cnt + 4'h1;
        end else if (fall) begin
          if (q.cnt == 4'h8) begin
            d.sda_oe = 1'b0;
            d.fsm = ST_RACK;
          end else begin
            d.sh = {q.sh[6:0], 1'b0};
            d.sda_oe = ~q.sh[6];
          end
        end
      end
      ST_RACK: begin
        if (rise) begin
          d.more = ~q.sda_s;
        end else if (fall) begin
          if (q.more) begin
            ld = 1'b1;
            d.cnt = 4'h0;
            d.fsm = ST_RD;
          end else begin
            d.fsm = ST_IDLE;
          end
        end
      end
      default: begin
      end
    endcase
    // Byte fetch and its read side effects
    if (ld) begin
      d.sh = rbyte;
      d.sda_oe = ~rbyte[7];
      d.ptr = q.ptr + 8'h1;
      if (q.ptr == A_CT) begin
        d.cfg.feat[FEAT_CTC] = 1'b0;
      end
      if (q.ptr == A_REL) begin
        d.evt = 3'h0;
        d.wax = 6'h0;
      end
      if (q.ptr == A_AX || q.ptr == A_AY || q.ptr == A_AZ) begin
        d.unread = 1'b0;
        d.ovr = 1'b0;
      end
    end
    if (wr) begin
      case (q.ptr)
        A_MAIN: d.cfg.main = q.sh;
        A_OMSK: d.cfg.omsk = q.sh;
        A_FEAT: d.cfg.feat = q.sh;
        A_IPIN: d.cfg.ipin = q.sh;
        A_AMSK: d.cfg.amsk = q.sh;
        A_TTIM: d.cfg.ttim = q.sh;
        A_WTIM: d.cfg.wtim = q.sh;
        A_BTIM: d.cfg.btim = q.sh;
        A_WTHR: d.cfg.wthr = q.sh;
        A_BTHR: d.cfg.bthr = q.sh;
        A_TANG: d.cfg.tang = q.sh;
        A_HYST: d.cfg.hyst = q.sh;
        default: begin
        end
      endcase
    end
    if (start) begin
      d.fsm = ST_ADDR;
      d.cnt = 4'h0;
      d.sda_oe = 1'b0;
    end else if (stop) begin
      d.fsm = ST_IDLE;
      d.sda_oe = 1'b0;
    end
    // Sets come after clears so a coinciding event survives
    d.pend = (core_in.tick | q.pend) & hold;
    if (go) begin
      d.ax = core_in.ax;
      d.ay = core_in.ay;
      d.az = core_in.az;
      d.unread = 1'b1;
      if (q.unread) begin
        d.ovr = 1'b1;
      end
      if (core_in.orient != q.ocur) begin
        d.opre = q.ocur;
        d.ocur = core_in.orient;
        if (q.cfg.main[MAIN_TPE] && |(q.cfg.omsk[5:0] & core_in.orient)) begin
          d.evt[EVT_ORIENT] = 1'b1;
        end
      end
    end
    if (core_in.wake && q.cfg.main[MAIN_WUFE]) begin
      d.evt[EVT_WAKE] = 1'b1;
      d.wax = core_in.wake_axis;
    end
    if (core_in.sleep && q.cfg.main[MAIN_B2SE]) begin
      d.evt[EVT_SLEEP] = 1'b1;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      q <= '0;
      q.scl_m <= 1'b1;
      q.scl_s <= 1'b1;
      q.scl_p <= 1'b1;
      q.sda_m <= 1'b1;
      q.sda_s <= 1'b1;
      q.sda_p <= 1'b1;
      q.ocur <= ORIENT_RST;
      q.opre <= ORIENT_RST;
      q.cfg.main <= MAIN_RST;
      q.cfg.omsk <= OMSK_RST;
      q.cfg.feat <= FEAT_RST;
      q.cfg.ipin <= IPIN_RST;
      q.cfg.amsk <= AMSK_RST;
      q.cfg.ttim <= TIM_RST;
      q.cfg.wtim <= TIM_RST;
      q.cfg.btim <= TIM_RST;
      q.cfg.wthr <= THR_RST;
      q.cfg.bthr <= THR_RST;
      q.cfg.tang <= TANG_RST;
      q.cfg.hyst <= HYST_RST;
    end else begin
      q <= d;
    end
  end

  // Open drain: only ever pulls low
  assign sda_out = 1'b0;
  assign sda_oe_out = q.sda_oe;
  assign cfg_out = q.cfg;
  assign rate_used_out = rate;
  assign irq_pin_out = (int_act & q.cfg.ipin[IPIN_IEN]) ? q.cfg.ipin[IPIN_IEA]
                       : ~q.cfg.ipin[IPIN_IEA];

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (sys_rst_in);

  comm_test_response_a: assert property (ld && q.ptr == A_CT |=>
    q.sh == ($past(q.cfg.feat[FEAT_CTC]) ? CT_ALT : CT_IDLE))
    else $error("test response byte wrong");
  ct_clear_a: assert property (ld && q.ptr == A_CT |=>
    !q.cfg.feat[FEAT_CTC] ##1 rbyte == CT_IDLE || q.ptr != A_CT)
    else $error("test request not cleared");
  orient_prev_a: assert property (go && core_in.orient != q.ocur |=>
    q.opre == $past(q.ocur) && q.ocur == $past(core_in.orient))
    else $error("previous orientation wrong");
  orient_hold_a: assert property (hold |=> $stable(q.ocur))
    else $error("orientation moved during read");
  overrun_set_a: assert property (go && q.unread && !ld |=> q.ovr)
    else $error("overrun missed");
  release_clr_a: assert property (ld && q.ptr == A_REL && !go &&
    !core_in.wake && !core_in.sleep |=> q.evt == 3'h0 ##0
    irq_pin_out == ~q.cfg.ipin[IPIN_IEA])
    else $error("release read did not clear events");
  status_rate_a: assert property (q.ptr == A_STAT |->
    rbyte[3:2] == rate_used_out && rbyte[4] == |q.evt)
    else $error("status byte wrong");
  addr_ack_a: assert property (q.fsm == ST_ADDR && fall && q.cnt == 4'h8 &&
    q.sh[7:1] == SLAVE_ADDR && !start && !stop |=> sda_oe_out)
    else $error("address not acknowledged");
  auto_inc_a: assert property (ld |=> q.ptr == $past(q.ptr) + 8'h1)
    else $error("address did not advance");
  // A tick that lands mid-byte must wait, not vanish
  tick_pend_a: assert property (hold && core_in.tick |=> q.pend)
    else $error("tick lost during read");
  ovr_clear_a: assert property (ld && !go && (q.ptr == A_AX ||
    q.ptr == A_AY || q.ptr == A_AZ) |=> !q.ovr)
    else $error("overrun not cleared by sample read");
  gap_zero_a: assert property ((q.ptr == 8'h15 ||
    q.ptr == 8'h19) |-> rbyte == 8'h00)
    else $error("unmapped address not zero");
  stop_idle_a: assert property (stop && !start |=>
    q.fsm == ST_IDLE && !sda_oe_out)
    else $error("stop did not release the bus");

  read_c: cover property (q.fsm == ST_RACK && fall && q.more);
  write_c: cover property (wr && q.ptr == A_FEAT);
  orient_c: cover property (go && core_in.orient != q.ocur);
  ovr_c: cover property (go && q.unread);
endmodule

// >>> tb/amc_host_model.sv
// Serial bus master model driving the register bank's slave port
`timescale 1ns/100ps
module amc_host_model (
  input wire logic mclk_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_oe_out
);
  initial begin
    scl_out = 1'b1;
    sda_oe_out = 1'b0;
  end

  task automatic step(input int n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask

  // Data moves early in the low phase, clear of the rising edge
  task automatic bit_io(input logic b, output logic r);
    step(1);
    sda_oe_out = ~b;
    step(3);
    scl_out = 1'b1;
    step(3);
    r = sda_in;
    step(1);
    scl_out = 1'b0;
  endtask

  // Long low phase lets the slave drop its acknowledge first
  task automatic start();
    step(1);
    sda_oe_out = 1'b0;
    step(5);
    scl_out = 1'b1;
    step(3);
    sda_oe_out = 1'b1;
    step(3);
    scl_out = 1'b0;
  endtask

  task automatic stop();
    step(1);
    sda_oe_out = 1'b1;
    step(5);
    scl_out = 1'b1;
    step(3);
    sda_oe_out = 1'b0;
    step(4);
  endtask

  task automatic put_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
    end
    bit_io(1'b1, r);
    ack = ~r;
  endtask

  task automatic get_byte(input logic more, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(~more, r);
  endtask
endmodule

// >>> tb/amc_regs_bench.sv
// Self-checking bench for the motion register bank
`timescale 1ns/100ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin fail_count++; \
  $display("wrong value at %0t: %h %h", $time, (a), (e)); end end
module amc_regs_bench;
  import amc_pkg::*;
  // Arbitrary supplier value
  localparam logic [7:0] SUP = 8'h3c;
  logic mclk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic scl, m_oe, d_oe, d_sda, sda, irq, ack;
  logic [1:0] rate;
  amc_core_t core = '0;
  amc_cfg_t cfg;
  int fail_count = 0;
  int checks = 0;
  int cyc = 0;
  logic [7:0] rb [0:8];
  logic [7:0] e0 [0:5] = '{CT_IDLE, 8'h00, 8'h00, SUP, 8'h20, 8'h20};
  logic [7:0] e1 [0:4] = '{8'h00, 8'h3f, 8'h06, 8'h08, 8'he0};
  logic [7:0] e2 [0:8] = '{8'h01, 8'h20, 8'ha8, 8'h54, 8'hfc, 8'h00,
    8'h01, 8'h00, 8'h14};
  logic [7:0] mk [0:8] = '{8'hff, 8'hff, 8'hfc, 8'hfc, 8'hfc, 8'hff,
    8'hff, 8'hff, 8'hff};

  // Open-drain wire with pull-up
  assign sda = ~m_oe & (~d_oe | d_sda);
  always #12.5 mclk_in = ~mclk_in;

  amc_regs #(.SUPPLIER_CODE(SUP)) dut_u (.mclk_in(mclk_in),
    .sys_rst_in(sys_rst_in), .scl_in(scl), .sda_in(sda), .sda_out(d_sda),
    .sda_oe_out(d_oe), .core_in(core), .cfg_out(cfg),
    .rate_used_out(rate), .irq_pin_out(irq));
  amc_host_model host_u (.mclk_in(mclk_in), .sda_in(sda), .scl_out(scl),
    .sda_oe_out(m_oe));

  task automatic finish_test();
    $display("checks %0d errors %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  always @(posedge mclk_in) begin
    cyc++;
    if (cyc == 30000) begin
      fail_count++;
      finish_test();
    end
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host_u.start();
    host_u.put_byte({SLAVE_ADDR, 1'b0}, ack);
    host_u.put_byte(a, ack);
    host_u.put_byte(d, ack);
    `CHK(ack, 1'b1)
    host_u.stop();
  endtask

  task automatic rd(input logic [7:0] a, input int n);
    host_u.start();
    host_u.put_byte({SLAVE_ADDR, 1'b0}, ack);
    host_u.put_byte(a, ack);
    host_u.start();
    host_u.put_byte({SLAVE_ADDR, 1'b1}, ack);
    for (int i = 0; i < n; i++) begin
      host_u.get_byte(i < n - 1, rb[i]);
    end
    host_u.stop();
  endtask

  task automatic core_pulse(input logic t, input logic w, input logic s);
    @(posedge mclk_in);
    #1;
    core.tick = t;
    core.wake = w;
    core.sleep = s;
    @(posedge mclk_in);
    #1;
    core.tick = 1'b0;
    core.wake = 1'b0;
    core.sleep = 1'b0;
  endtask

  initial begin
    repeat (5) @(posedge mclk_in);
    #1;
    sys_rst_in = 1'b0;
    `CHK(irq, 1'b0)
    repeat (4) @(posedge mclk_in);
    rd(A_CT, 6);
    foreach (e0[i]) `CHK(rb[i], e0[i])
    rd(A_MAIN, 5);
    foreach (e1[i]) `CHK(rb[i], e1[i])
    // Foreign slave address stays unanswered
    host_u.start();
    host_u.put_byte(8'h1c, ack);
    `CHK(ack, 1'b0)
    host_u.stop();
    wr(8'h15, 8'hff);
    wr(A_OCUR, 8'h01);
    wr(A_MAIN, 8'h07);
    `CHK(cfg.main, 8'h07)
    rd(8'h15, 1);
    `CHK(rb[0], 8'h00)
    rd(A_OCUR, 1);
    `CHK(rb[0], 8'h20)
    wr(A_FEAT, 8'h16);
    rd(A_CT, 1);
    `CHK(rb[0], CT_ALT)
    rd(A_CT, 1);
    `CHK(rb[0], CT_IDLE)
    rd(A_FEAT, 1);
    `CHK(rb[0], 8'h06)
    core.orient = 6'h01;
    core.ax = 6'h2a;
    core.ay = 6'h15;
    core.az = 6'h3f;
    core_pulse(1'b1, 1'b0, 1'b0);
    rd(A_OCUR, 9);
    foreach (e2[i]) `CHK(rb[i] & mk[i], e2[i])
    wr(A_IPIN, 8'h18);
    `CHK(irq, 1'b1)
    rd(A_REL, 1);
    `CHK(irq, 1'b0)
    rd(A_EVT, 3);
    `CHK({rb[0], rb[2]}, 16'h0004)
    core.active = 1'b1;
    core.wake_axis = 6'h10;
    core_pulse(1'b0, 1'b1, 1'b0);
    `CHK(rate, 2'h2)
    rd(A_EVT, 3);
    `CHK({rb[0], rb[1], rb[2]}, 24'h021018)
    core.active = 1'b0;
    core_pulse(1'b0, 1'b0, 1'b1);
    `CHK(rate, 2'h1)
    rd(A_EVT, 1);
    `CHK(rb[0], 8'h06)
    for (int k = 0; k < 4; k++) begin
      wr(A_MAIN, {3'h0, k[1:0], 3'h0});
      `CHK(rate, k[1:0])
      rd(A_STAT, 1);
      `CHK(rb[0], {4'h1, k[1:0], 2'h0})
    end
    core_pulse(1'b1, 1'b0, 1'b0);
    core_pulse(1'b1, 1'b0, 1'b0);
    rd(A_STAT, 1);
    `CHK(rb[0], 8'h3c)
    rd(A_AX, 1);
    rd(A_STAT, 1);
    `CHK(rb[0], 8'h1c)
    // Tick arrives while the sample byte is being shifted out
    core.ax = 6'h01;
    fork
      rd(A_AX, 2);
      begin
        repeat (280) @(posedge mclk_in);
        core_pulse(1'b1, 1'b0, 1'b0);
      end
    join
    `CHK({rb[0] & 8'hfc, rb[1] & 8'hfc}, 16'ha854)
    rd(A_AX, 1);
    `CHK(rb[0] & 8'hfc, 8'h04)
    finish_test();
  end
endmodule
